/* File: core/pio_defs.vh */
// Constants for the programmable I/O port bank
`ifndef PIO_DEFS_VH
`define PIO_DEFS_VH

// ----------------------------------------
// Port selects and implemented-bit masks
// ----------------------------------------
`define PIO_NPORTS 5
`define PIO_PORT0 3'h0
`define PIO_PORT1 3'h1
`define PIO_PORT2 3'h2
`define PIO_PORT3 3'h3
`define PIO_PORT4 3'h4
`define PIO_DIR_MASK0 8'h2f
`define PIO_DIR_MASK1 8'hff
`define PIO_DIR_MASK2 8'hff
`define PIO_DIR_MASK3 8'h38
`define PIO_DIR_MASK4 8'h20
`define PIO_DATA_MASK0 8'h2f
`define PIO_DATA_MASK1 8'hff
`define PIO_DATA_MASK2 8'hff
`define PIO_DATA_MASK3 8'h38
`define PIO_DATA_MASK4 8'he4

// ----------------------------------------
// Reset values and pull-up fields
// ----------------------------------------
`define PIO_DIR_RESET 8'h00
`define PIO_LATCH_RESET 8'h00
`define PIO_PU_RESET 8'h00
`define PIO_PU0_MASK 8'h3f
`define PIO_PU1_MASK 8'h07
// Pull-up control 0: one bit per group
`define PIO_PU0_P0LO 0
`define PIO_PU0_P0B5 1
`define PIO_PU0_P1LO 2
`define PIO_PU0_P1HI 3
`define PIO_PU0_P2LO 4
`define PIO_PU0_P2HI 5
// Pull-up control 1
`define PIO_PU1_P3B3 0
`define PIO_PU1_P3HI 1
`define PIO_PU1_P4B5 2

`endif

/* File: core/pio_port.v */
// One 8-bit port: direction, latch, read mux and pin drive
`timescale 1ns/1ps
`include "pio_defs.vh"
module pio_port #(
  parameter [7:0] DIR_MASK = 8'hff,
  parameter [7:0] DATA_MASK = 8'hff
) (
  input wire i_clk,
  input wire i_resetn,
  input wire i_dir_we,
  input wire i_data_we,
  input wire [7:0] i_wdata,
  input wire [7:0] i_pin_in,
  input wire [7:0] i_per_oe,
  input wire [7:0] i_per_out,
  input wire [7:0] i_pu_sel,
  output wire [7:0] o_dir,
  output wire [7:0] o_data_rd,
  output wire [7:0] o_pin_out,
  output wire [7:0] o_pin_oe_n,
  output wire [7:0] o_pullup
);
  reg [7:0] dir;
  reg [7:0] latch;
  wire [7:0] drive;

  always @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      dir <= `PIO_DIR_RESET;
      latch <= `PIO_LATCH_RESET;
    end
    else
    begin
      if (i_dir_we)
        dir <= i_wdata & DIR_MASK;
      if (i_data_we)
        latch <= i_wdata & DATA_MASK;
    end
  end

  assign o_dir = dir;
  // Input bits show the pin, output bits the latch
  assign o_data_rd = ((dir & latch) | (~dir & i_pin_in)) & DATA_MASK;
  // Peripheral output wins over the direction bit
  assign drive = (dir | (i_per_oe & DATA_MASK)) & DIR_MASK;
  assign o_pin_out = (i_per_oe & i_per_out) |
                     (~i_per_oe & latch & dir);
  assign o_pin_oe_n = ~drive;
  // Pull-up only while the pin is not driven
  assign o_pullup = i_pu_sel & ~drive & DIR_MASK;
endmodule

/* File: core/pio_bank.v */
// Programmable I/O port bank: five ports with write-protected port 0 direction
`timescale 1ns/1ps
module pio_bank (
  input wire i_clk,
  input wire i_resetn,
  input wire [2:0] i_port_sel,
  input wire i_dir_we,
  input wire i_data_we,
  input wire [7:0] i_wdata,
  input wire i_unlock_set,
  input wire i_insn_done,
  input wire i_pu0_we,
  input wire i_pu1_we,
  input wire [39:0] i_pin_in,
  input wire [39:0] i_per_oe,
  input wire [39:0] i_per_out,
  output reg [7:0] o_dir_rd,
  output reg [7:0] o_data_rd,
  output wire [7:0] o_pullup_control_0,
  output wire [7:0] o_pullup_control_1,
  output wire o_direction_write_unlock_bit,
  output wire [39:0] o_pin_out,
  output wire [39:0] o_pin_oe_n,
  output wire [39:0] o_pullup
);
`include "pio_defs.vh"

  // ----------------------------------------
  // Port 0 direction write protection
  // ----------------------------------------
  // Unlock lasts for the one instruction following the set
  reg unlock;
  reg unlock_armed;
  reg [7:0] pu0;
  reg [7:0] pu1;

  always @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      unlock <= 1'b0;
      unlock_armed <= 1'b0;
    end
    else if (i_unlock_set)
    begin
      unlock <= 1'b1;
      // Set instruction may end on this very edge
      unlock_armed <= i_insn_done;
    end
    else if (i_insn_done && unlock)
    begin
      // End of the set instruction arms; the next one closes the window
      if (unlock_armed)
        unlock <= 1'b0;
      unlock_armed <= ~unlock_armed;
    end
  end

  assign o_direction_write_unlock_bit = unlock;

  // ----------------------------------------
  // Pull-up control registers
  // ----------------------------------------
  always @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      pu0 <= `PIO_PU_RESET;
      pu1 <= `PIO_PU_RESET;
    end
    else
    begin
      if (i_pu0_we)
        pu0 <= i_wdata & `PIO_PU0_MASK;
      if (i_pu1_we)
        pu1 <= i_wdata & `PIO_PU1_MASK;
    end
  end

  assign o_pullup_control_0 = pu0;
  assign o_pullup_control_1 = pu1;

  // Expand grouped controls to per-pin selects
  wire [39:0] pu_sel;
  assign pu_sel[7:0] = {2'h0, pu0[`PIO_PU0_P0B5], 1'b0,
                        {4{pu0[`PIO_PU0_P0LO]}}};
  assign pu_sel[15:8] = {{4{pu0[`PIO_PU0_P1HI]}},
                         {4{pu0[`PIO_PU0_P1LO]}}};
  assign pu_sel[23:16] = {{4{pu0[`PIO_PU0_P2HI]}},
                          {4{pu0[`PIO_PU0_P2LO]}}};
  assign pu_sel[31:24] = {2'h0, {2{pu1[`PIO_PU1_P3HI]}},
                          pu1[`PIO_PU1_P3B3], 3'h0};
  assign pu_sel[39:32] = {2'h0, pu1[`PIO_PU1_P4B5], 5'h00};

  // ----------------------------------------
  // Port instances
  // ----------------------------------------
  wire [39:0] dir_all;
  wire [39:0] rd_all;
  wire p0_dir_ok;
  assign p0_dir_ok = unlock;

  genvar g;
  generate
    for (g = 0; g < `PIO_NPORTS; g = g + 1)
    begin : gen_port
      localparam [7:0] DM = (g == 0) ? `PIO_DIR_MASK0 :
                            (g == 1) ? `PIO_DIR_MASK1 :
                            (g == 2) ? `PIO_DIR_MASK2 :
                            (g == 3) ? `PIO_DIR_MASK3 : `PIO_DIR_MASK4;
      localparam [7:0] AM = (g == 0) ? `PIO_DATA_MASK0 :
                            (g == 1) ? `PIO_DATA_MASK1 :
                            (g == 2) ? `PIO_DATA_MASK2 :
                            (g == 3) ? `PIO_DATA_MASK3 : `PIO_DATA_MASK4;
      wire sel;
      wire dir_we;
      assign sel = ({29'h0, i_port_sel} == g);
      // Port 0 direction ignores writes while locked
      assign dir_we = i_dir_we && sel && ((g != 0) || p0_dir_ok);
      pio_port #(
        .DIR_MASK(DM),
        .DATA_MASK(AM)
      ) u_port (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_dir_we(dir_we),
        .i_data_we(i_data_we && sel),
        .i_wdata(i_wdata),
        .i_pin_in(i_pin_in[g*8 +: 8]),
        .i_per_oe(i_per_oe[g*8 +: 8]),
        .i_per_out(i_per_out[g*8 +: 8]),
        .i_pu_sel(pu_sel[g*8 +: 8]),
        .o_dir(dir_all[g*8 +: 8]),
        .o_data_rd(rd_all[g*8 +: 8]),
        .o_pin_out(o_pin_out[g*8 +: 8]),
        .o_pin_oe_n(o_pin_oe_n[g*8 +: 8]),
        .o_pullup(o_pullup[g*8 +: 8])
      );
    end
  endgenerate

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @*
  begin
    case (i_port_sel)
      `PIO_PORT0:
      begin
        o_dir_rd = dir_all[7:0];
        o_data_rd = rd_all[7:0];
      end
      `PIO_PORT1:
      begin
        o_dir_rd = dir_all[15:8];
        o_data_rd = rd_all[15:8];
      end
      `PIO_PORT2:
      begin
        o_dir_rd = dir_all[23:16];
        o_data_rd = rd_all[23:16];
      end
      `PIO_PORT3:
      begin
        o_dir_rd = dir_all[31:24];
        o_data_rd = rd_all[31:24];
      end
      `PIO_PORT4:
      begin
        o_dir_rd = dir_all[39:32];
        o_data_rd = rd_all[39:32];
      end
      default:
      begin
        // Unmapped port reads zero
        o_dir_rd = 8'h00;
        o_data_rd = 8'h00;
      end
    endcase
  end
endmodule

/* File: tb/pio_pins.sv */
// Pin model for the port bank: drivers, pull-ups and floating lines
`timescale 1ns/1ps
module pio_pins (
  input wire i_clk,
  input wire [39:0] i_out,
  input wire [39:0] i_oe_n,
  input wire [39:0] i_pu,
  output wire [39:0] o_pin
);
  integer seed = 51;
  reg [63:0] ext = 64'h0;
  always @(posedge i_clk)
    ext <= {$random(seed), $random(seed)};
  // Floating lines get fresh noise, never the last driven level
  assign o_pin = ~i_oe_n & i_out | i_oe_n & i_pu |
    i_oe_n & ~i_pu & ext[39:0];
endmodule

/* File: tb/pio_bank_assertions.sv */
// Checker on the port-bank ports
`timescale 1ns/1ps
module pio_bank_assertions (
  input wire i_clk,
  input wire i_resetn,
  input wire [2:0] i_port_sel,
  input wire i_dir_we,
  input wire i_unlock_set,
  input wire i_insn_done,
  input wire [39:0] i_pin_in,
  input wire [39:0] i_per_oe,
  input wire [7:0] o_dir_rd,
  input wire [7:0] o_data_rd,
  input wire [7:0] o_pullup_control_0,
  input wire o_direction_write_unlock_bit,
  input wire [39:0] o_pin_oe_n,
  input wire [39:0] o_pullup
);
  wire ul = o_direction_write_unlock_bit;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  AST_OE: assert property (i_port_sel == 3'h1 |->
    o_pin_oe_n[15:8] == ~(o_dir_rd | i_per_oe[15:8])) else $error("oe");
  AST_RD: assert property (i_port_sel == 3'h2 && !o_dir_rd |->
    o_data_rd == i_pin_in[23:16]) else $error("rd");
  AST_D0: assert property (i_port_sel == 3'h0 |->
    !(o_dir_rd & 8'hd0)) else $error("d0");
  AST_P4: assert property (i_port_sel == 3'h4 |->
    !(o_data_rd & 8'h1b)) else $error("p4");
  AST_LK: assert property (!ul && i_dir_we && i_port_sel == 3'h0 |=>
    i_port_sel != 3'h0 || $stable(o_dir_rd)) else $error("lk");
  AST_UL: assert property (i_unlock_set |=> ul) else $error("ul");
  AST_UE: assert property ((ul && i_insn_done && !i_unlock_set) [*2]
    |=> !ul) else $error("ue");
  AST_PU: assert property (!(o_pullup & ~o_pin_oe_n))
    else $error("pu");
  AST_GR: assert property (o_pullup[1] ==
    (o_pullup_control_0[0] & o_pin_oe_n[1])) else $error("gr");
  AST_IO: assert property (&o_pin_oe_n[39:38] && o_pin_oe_n[34] &&
    !o_pullup[34]) else $error("io");
  cover property (i_unlock_set ##1 i_dir_we && i_port_sel == 3'h0);
  cover property (ul ##1 !ul);
  cover property (|o_pullup);
endmodule
bind pio_bank pio_bank_assertions u_chk (
  .i_clk(i_clk),
  .i_resetn(i_resetn),
  .i_port_sel(i_port_sel),
  .i_dir_we(i_dir_we),
  .i_unlock_set(i_unlock_set),
  .i_insn_done(i_insn_done),
  .i_pin_in(i_pin_in),
  .i_per_oe(i_per_oe),
  .o_dir_rd(o_dir_rd),
  .o_data_rd(o_data_rd),
  .o_pullup_control_0(o_pullup_control_0),
  .o_direction_write_unlock_bit(o_direction_write_unlock_bit),
  .o_pin_oe_n(o_pin_oe_n),
  .o_pullup(o_pullup)
);

/* File: tb/pio_bank_tb_top.sv */
// Random self-checking bench for the port bank
`timescale 1ns/1ps
module pio_bank_tb_top;
  reg i_clk = 0, i_resetn = 0, i_dir_we = 0, i_data_we = 0, mu = 0;
  reg i_unlock_set = 0, i_insn_done = 0, i_pu0_we = 0, i_pu1_we = 0;
  reg [2:0] i_port_sel = 0;
  reg [7:0] i_wdata = 0, m0 = 0, m1 = 0, e;
  reg [39:0] i_per_oe = 0, i_per_out = 0, d = 0, l = 0, x;
  reg [63:0] r;
  integer n = 0, k, seed = 51, mismatches = 0, n_checks = 0;
  wire [39:0] i_pin_in, o_pin_out, o_pin_oe_n, o_pullup;
  wire [7:0] o_dir_rd, o_data_rd, o_pullup_control_0, o_pullup_control_1;
  wire o_direction_write_unlock_bit;
  wire [5:0] b = {i_port_sel, 3'h0};
  wire v = i_port_sel < 3'h5;
  localparam [39:0] DM = 40'h2038ffff2f, AM = 40'he438ffff2f;
  always #12.5 i_clk = ~i_clk;
  pio_bank u_dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_port_sel(i_port_sel),
    .i_dir_we(i_dir_we), .i_data_we(i_data_we), .i_wdata(i_wdata),
    .i_unlock_set(i_unlock_set), .i_insn_done(i_insn_done),
    .i_pu0_we(i_pu0_we), .i_pu1_we(i_pu1_we), .i_pin_in(i_pin_in),
    .i_per_oe(i_per_oe), .i_per_out(i_per_out), .o_dir_rd(o_dir_rd),
    .o_data_rd(o_data_rd), .o_pullup_control_0(o_pullup_control_0),
    .o_pullup_control_1(o_pullup_control_1),
    .o_direction_write_unlock_bit(o_direction_write_unlock_bit),
    .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n), .o_pullup(o_pullup));
  pio_pins u_pins (.i_clk(i_clk), .i_out(o_pin_out), .i_oe_n(o_pin_oe_n),
    .i_pu(o_pullup), .o_pin(i_pin_in));
  task check(input [39:0] got, input [39:0] exp);
  begin
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  end
  endtask
  task cyc(input [1:0] md);
  begin
    @(posedge i_clk);
    if (v && i_dir_we && (b != 0 || mu))
      d[b +: 8] = i_wdata & DM[b +: 8];
    if (v && i_data_we)
      l[b +: 8] = i_wdata & AM[b +: 8];
    if (i_pu0_we)
      m0 = i_wdata & 8'h3f;
    if (i_pu1_we)
      m1 = i_wdata & 8'h07;
    n = i_unlock_set ? i_insn_done : n + (mu && i_insn_done);
    mu = i_unlock_set || (mu && n < 2);
    r = {$random(seed), $random(seed)};
    // Peripheral-input mode: port 1 direction cleared, no peripheral drive
    {i_port_sel, i_dir_we, i_data_we, i_insn_done, i_wdata} <=
      md[1] ? 14'h0c00 : r[13:0];
    i_unlock_set <= md[0] & ~|r[16:14];
    i_pu0_we <= &r[18:17];
    i_pu1_we <= &r[20:19];
    r = {$random(seed), $random(seed)};
    // Sparse peripheral claims keep most pins under port control
    i_per_oe <= md[1] ? 40'h0 : r[39:0] & r[63:24];
    i_per_out <= r[63:24];
    @(negedge i_clk);
    x = ~(d | i_per_oe & DM);
    e = AM[b +: 8] & (d[b +: 8] & l[b +: 8] | ~d[b +: 8] & i_pin_in[b +: 8]);
    check(o_data_rd, v ? e : 8'h0);
    check(o_dir_rd, v ? d[b +: 8] : 8'h0);
    check(o_pin_oe_n, x);
    check(o_pin_out & ~x,
      (i_per_oe & i_per_out | ~i_per_oe & l & d) & ~x);
    check(o_pullup, {2'h0, m1[2], 7'h0, {2{m1[1]}}, m1[0], 3'h0,
      {4{m0[5]}}, {4{m0[4]}}, {4{m0[3]}}, {4{m0[2]}}, 2'h0, m0[1], 1'h0,
      {4{m0[0]}}} & x);
    check({o_pullup_control_1, o_pullup_control_0}, {m1, m0});
    check(o_direction_write_unlock_bit, mu);
  end
  endtask
  task give_verdict;
  begin
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  initial
  begin
    repeat (3) @(posedge i_clk);
    i_resetn <= 1;
    // Port 0 write straight out of reset must be refused
    i_dir_we <= 1;
    i_wdata <= 8'hff;
    for (k = 0; k < 300; k = k + 1)
      cyc(2'h0);
    $display("locked test done");
    for (k = 0; k < 3000; k = k + 1)
      cyc(2'h1);
    $display("random test done");
    for (k = 0; k < 4; k = k + 1)
      cyc(2'h2);
    check(o_pin_oe_n[15:8], 8'hff);
    check(o_data_rd, i_pin_in[15:8]);
    $display("peripheral input test done");
    give_verdict;
  end
endmodule
